// ---- include/dsc_pkg.sv ----
// constants, types and bundles shared by the startup/status-led block
// assumes a single 125 MHz clock and one asynchronous power-on reset
package dsc_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned HALL_HOLD_MS = 1000;
  localparam int unsigned FLICKER_MS = 50;
  localparam int unsigned BLINK_MS = 200;
  localparam int unsigned LONG_OFF_MS = 1000;
  localparam int unsigned HALL_HOLD_CYC = HALL_HOLD_MS * CYC_PER_MS;
  localparam int unsigned FLICKER_CYC = FLICKER_MS * CYC_PER_MS;
  localparam int unsigned BLINK_CYC = BLINK_MS * CYC_PER_MS;
  // flash patterns are built from blink-length slots
  localparam int unsigned LONG_OFF_SLOTS = LONG_OFF_MS / BLINK_MS;
  localparam int unsigned SINGLE_SLOTS = 1 + LONG_OFF_SLOTS;
  localparam int unsigned DOUBLE_SLOTS = 3 + LONG_OFF_SLOTS;
  localparam int unsigned CNT_W = 27;
  localparam int unsigned SLOT_W = 4;
  localparam logic [1:0] SETTLE_CYC = 2'h3;

  // ----------------------------------------------------------------
  // register map (byte addresses) and fields
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_MERR = 8'h08;
  localparam logic [7:0] ADDR_STRAPS = 8'h0C;
  localparam int unsigned CTRL_HW_SEL_BIT = 0;
  localparam int unsigned CTRL_AL_CLR_BIT = 1;
  localparam int unsigned MERR_INVALID_SETUP_BIT = 2;
  localparam logic [7:0] DEFAULT_NODE = 8'hFF;
  localparam logic [7:0] NODE_MIN = 8'h01;
  localparam logic CTRL_HW_SEL_RST = 1'b0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ----------------------------------------------------------------
  // nonvolatile autorun disable word
  // ----------------------------------------------------------------
  localparam logic [15:0] EE_DISABLE_ADDR = 16'h2000;
  localparam logic [15:0] EE_DISABLE_VAL = 16'h0001;

  // ----------------------------------------------------------------
  // fieldbus slave states as reported by the slave state machine
  // ----------------------------------------------------------------
  localparam logic [3:0] SLV_INIT = 4'h1;
  localparam logic [3:0] SLV_PREOP = 4'h2;
  localparam logic [3:0] SLV_SAFEOP = 4'h4;
  localparam logic [3:0] SLV_OP = 4'h8;

  typedef enum logic [5:0] {
    ST_SETTLE = 6'h01,
    ST_HALL = 6'h02,
    ST_DECIDE = 6'h04,
    ST_ARMED = 6'h08,
    ST_RUN = 6'h10,
    ST_SLAVE = 6'h20
  } dsc_start_e;

  // pins that enter from outside the clock domain
  typedef struct packed {
    logic [2:0] hall;
    logic [3:0] node_sw;
    logic [1:0] axis_idx;
    logic proto_sw;
    logic override_sw;
    logic sw_variant;
    logic port0_link;
    logic port1_link;
    logic motor_supply;
  } dsc_pins_s;

  // indicator patterns, a = base phase, b = half a period later
  typedef struct packed {
    logic flicker;
    logic blink_a;
    logic blink_b;
    logic single_a;
    logic single_b;
    logic double_a;
    logic double_b;
  } dsc_pat_s;

endpackage

// ---- rtl/dsc_led_pattern.sv ----
// indicator pattern timebase: flicker, blink, single and double flash
// assumes the same clock and reset as the top; counts are parameters
module dsc_led_pattern #(
  parameter int unsigned P_FLICKER_CYC = dsc_pkg::FLICKER_CYC,
  parameter int unsigned P_SLOT_CYC = dsc_pkg::BLINK_CYC
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  output dsc_pkg::dsc_pat_s o_pat
);

  typedef struct packed {
    logic [dsc_pkg::CNT_W-1:0] fl_cnt;
    logic fl;
    logic [dsc_pkg::CNT_W-1:0] sl_cnt;
    logic bl;
    logic [dsc_pkg::SLOT_W-1:0] s6;
    logic [dsc_pkg::SLOT_W-1:0] s8;
    dsc_pkg::dsc_pat_s pat;
  } dsc_pat_state_s;

  localparam logic [dsc_pkg::SLOT_W-1:0] S6_LAST =
    dsc_pkg::SLOT_W'(dsc_pkg::SINGLE_SLOTS - 1);
  localparam logic [dsc_pkg::SLOT_W-1:0] S8_LAST =
    dsc_pkg::SLOT_W'(dsc_pkg::DOUBLE_SLOTS - 1);
  localparam logic [dsc_pkg::SLOT_W-1:0] S6_HALF =
    dsc_pkg::SLOT_W'(dsc_pkg::SINGLE_SLOTS / 2);
  localparam logic [dsc_pkg::SLOT_W-1:0] S8_HALF =
    dsc_pkg::SLOT_W'(dsc_pkg::DOUBLE_SLOTS / 2);

  dsc_pat_state_s q_ff;
  dsc_pat_state_s nxt_q;

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    logic [dsc_pkg::SLOT_W-1:0] s6b;
    logic [dsc_pkg::SLOT_W-1:0] s8b;
    nxt_q = q_ff;
    s6b = '0;
    s8b = '0;
    if (q_ff.fl_cnt == dsc_pkg::CNT_W'(P_FLICKER_CYC - 1)) begin
      nxt_q.fl_cnt = '0;
      nxt_q.fl = ~q_ff.fl;
    end else begin
      nxt_q.fl_cnt = q_ff.fl_cnt + 1'b1;
    end
    if (q_ff.sl_cnt == dsc_pkg::CNT_W'(P_SLOT_CYC - 1)) begin
      nxt_q.sl_cnt = '0;
      nxt_q.bl = ~q_ff.bl;
      nxt_q.s6 = (q_ff.s6 == S6_LAST) ? '0 : q_ff.s6 + 1'b1;
      nxt_q.s8 = (q_ff.s8 == S8_LAST) ? '0 : q_ff.s8 + 1'b1;
    end else begin
      nxt_q.sl_cnt = q_ff.sl_cnt + 1'b1;
    end
    // shifted slot indices give the half-period phase
    s6b = (q_ff.s6 >= S6_HALF) ? q_ff.s6 - S6_HALF : q_ff.s6 + S6_HALF;
    s8b = (q_ff.s8 >= S8_HALF) ? q_ff.s8 - S8_HALF : q_ff.s8 + S8_HALF;
    nxt_q.pat.flicker = q_ff.fl;
    nxt_q.pat.blink_a = q_ff.bl;
    nxt_q.pat.blink_b = ~q_ff.bl;
    nxt_q.pat.single_a = (q_ff.s6 == '0);
    nxt_q.pat.single_b = (s6b == '0);
    nxt_q.pat.double_a = (q_ff.s8 == '0) || (q_ff.s8 == 4'h2);
    nxt_q.pat.double_b = (s8b == '0) || (s8b == 4'h2);
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign o_pat = q_ff.pat;

endmodule // dsc_led_pattern

// ---- rtl/dsc_startup_top.sv ----
// power-up configuration, autorun decision and fieldbus status leds
// assumes straps/halls/links arrive as raw pins, the slave state machine,
// error flags and nonvolatile contents come from logic on I_CLK
module dsc_startup_top #(
  parameter int unsigned P_HALL_HOLD_CYC = dsc_pkg::HALL_HOLD_CYC,
  parameter int unsigned P_FLICKER_CYC = dsc_pkg::FLICKER_CYC,
  parameter int unsigned P_SLOT_CYC = dsc_pkg::BLINK_CYC
) (
  input wire logic I_CLK,
  input wire logic I_ARST_N,
  // pins
  input wire logic [2:0] I_HALL,
  input wire logic [3:0] I_NODE_NUMBER_SWITCH,
  input wire logic [1:0] I_AXIS_INDEX,
  input wire logic I_PROTOCOL_SELECT_SWITCH,
  input wire logic I_MODE_OVERRIDE_SWITCH,
  input wire logic I_SWITCH_VARIANT,
  input wire logic I_PORT0_LINK,
  input wire logic I_PORT1_LINK,
  input wire logic I_MOTOR_SUPPLY,
  // same-clock logic
  input wire logic [15:0] I_EE_DISABLE_WORD,
  input wire logic I_PROG_VALID,
  input wire logic I_SETUP_VALID,
  input wire logic I_SETUP_RESET_LOOP,
  input wire logic [3:0] I_SLAVE_STATE,
  input wire logic I_ERR_CRITICAL,
  input wire logic I_ERR_WATCHDOG,
  input wire logic I_ERR_LOCAL_EVT,
  input wire logic I_ERR_CONFIG,
  // outputs
  output logic [15:0] O_EE_DISABLE_ADDR,
  output logic O_RUN_LED,
  output logic O_ERR_LED,
  output logic [7:0] O_NODE_NUMBER,
  output logic O_NATIVE_CAN_MODE,
  output logic O_LSS_INACTIVE,
  output logic O_SLAVE_MODE,
  output logic O_PROG_START,
  output logic O_LOAD_DEFAULTS,
  output logic O_AL_ERR_IND,
  output logic O_UPSTREAM_OK,
  // AXI4-Lite slave
  input wire logic [7:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [7:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY
);

  typedef struct packed {
    dsc_pkg::dsc_pins_s meta;
    dsc_pkg::dsc_pins_s pins;
    dsc_pkg::dsc_start_e st;
    logic [1:0] settle;
    logic [dsc_pkg::CNT_W-1:0] hold;
    dsc_pkg::dsc_pins_s strap;
    logic hall_gnd;
    logic native_can;
    logic autorun_en;
    logic setup_ok;
    logic load_def;
    logic prog_start;
    logic hw_sel;
    logic [7:0] sw_node;
    logic [7:0] node;
    logic lss_inact;
    logic al_err;
    logic merr_bad_setup;
    logic run_led;
    logic err_led;
    logic aw_got;
    logic [7:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } dsc_top_state_s;

  dsc_top_state_s q_ff;
  dsc_top_state_s nxt_q;
  dsc_pkg::dsc_pat_s pat;
  dsc_pkg::dsc_pins_s raw;

  dsc_led_pattern #(
    .P_FLICKER_CYC(P_FLICKER_CYC),
    .P_SLOT_CYC(P_SLOT_CYC)
  ) u_pat (
    .i_clk(I_CLK),
    .i_arst_n(I_ARST_N),
    .o_pat(pat)
  );

  always_comb begin
    raw.hall = I_HALL;
    raw.node_sw = I_NODE_NUMBER_SWITCH;
    raw.axis_idx = I_AXIS_INDEX;
    raw.proto_sw = I_PROTOCOL_SELECT_SWITCH;
    raw.override_sw = I_MODE_OVERRIDE_SWITCH;
    raw.sw_variant = I_SWITCH_VARIANT;
    raw.port0_link = I_PORT0_LINK;
    raw.port1_link = I_PORT1_LINK;
    raw.motor_supply = I_MOTOR_SUPPLY;
  end

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    logic halls_low;
    logic inhibit;
    logic use_hw;
    logic ctrl_wr;
    logic al_clr;
    logic [7:0] hw_node;
    logic [31:0] rd;
    logic rd_hit;
    nxt_q = q_ff;
    halls_low = 1'b0;
    inhibit = 1'b0;
    use_hw = 1'b0;
    ctrl_wr = 1'b0;
    al_clr = 1'b0;
    hw_node = '0;
    rd = '0;
    rd_hit = 1'b0;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    nxt_q.meta = raw;
    nxt_q.pins = q_ff.meta;
    halls_low = (q_ff.pins.hall == '0);
    nxt_q.prog_start = 1'b0;

    // ----------------------------------------------------------------
    // power-up sequence
    // ----------------------------------------------------------------
    unique case (q_ff.st)
      dsc_pkg::ST_SETTLE: begin
        // wait until the synchronisers hold real pin levels
        nxt_q.settle = q_ff.settle + 1'b1;
        if (q_ff.settle == dsc_pkg::SETTLE_CYC) begin
          nxt_q.strap = q_ff.pins;
          nxt_q.st = dsc_pkg::ST_HALL;
        end
      end
      dsc_pkg::ST_HALL: begin
        if (!halls_low) begin
          nxt_q.st = dsc_pkg::ST_DECIDE;
        end else if (q_ff.hold ==
                     dsc_pkg::CNT_W'(P_HALL_HOLD_CYC - 1)) begin
          nxt_q.hall_gnd = 1'b1;
          nxt_q.st = dsc_pkg::ST_DECIDE;
        end else begin
          nxt_q.hold = q_ff.hold + 1'b1;
        end
      end
      dsc_pkg::ST_DECIDE: begin
        // protocol switch on = native CAN, override forces CANopen
        nxt_q.native_can = q_ff.strap.proto_sw &
                           ~q_ff.strap.override_sw;
        nxt_q.load_def = q_ff.strap.sw_variant & q_ff.hall_gnd;
        nxt_q.merr_bad_setup = q_ff.strap.sw_variant & q_ff.hall_gnd;
        nxt_q.setup_ok = I_SETUP_VALID &
                         ~(q_ff.strap.sw_variant & q_ff.hall_gnd);
        inhibit = (I_EE_DISABLE_WORD == dsc_pkg::EE_DISABLE_VAL)
                | ~(q_ff.strap.proto_sw & ~q_ff.strap.override_sw)
                | q_ff.hall_gnd
                | ~I_PROG_VALID;
        nxt_q.autorun_en = ~inhibit;
        nxt_q.st = inhibit ? dsc_pkg::ST_SLAVE : dsc_pkg::ST_ARMED;
      end
      dsc_pkg::ST_ARMED: begin
        if (q_ff.pins.motor_supply) begin
          nxt_q.prog_start = 1'b1;
          nxt_q.st = dsc_pkg::ST_RUN;
        end
      end
      dsc_pkg::ST_RUN: begin
      end
      dsc_pkg::ST_SLAVE: begin
      end
      default: begin
        nxt_q.st = dsc_pkg::ST_SLAVE;
      end
    endcase

    // ----------------------------------------------------------------
    // node number
    // ----------------------------------------------------------------
    // position 4 weighs 8, position 1 weighs 64, axis adds 1..4
    hw_node = {1'b0, q_ff.strap.node_sw, 3'h0}
            + {6'h00, q_ff.strap.axis_idx} + dsc_pkg::NODE_MIN;
    use_hw = q_ff.hw_sel | ~q_ff.setup_ok;
    if (q_ff.st == dsc_pkg::ST_SETTLE || q_ff.st == dsc_pkg::ST_HALL ||
        q_ff.st == dsc_pkg::ST_DECIDE) begin
      nxt_q.node = dsc_pkg::DEFAULT_NODE;
    end else begin
      nxt_q.node = use_hw ? hw_node : q_ff.sw_node;
    end
    nxt_q.lss_inact = ~nxt_q.native_can &
                      (nxt_q.node == dsc_pkg::DEFAULT_NODE);

    // ----------------------------------------------------------------
    // AXI4-Lite write
    // ----------------------------------------------------------------
    if (I_AWVALID && O_AWREADY) begin
      nxt_q.aw_got = 1'b1;
      nxt_q.awaddr = I_AWADDR;
    end
    if (I_WVALID && O_WREADY) begin
      nxt_q.w_got = 1'b1;
      nxt_q.wdata = I_WDATA;
      nxt_q.wstrb = I_WSTRB;
    end
    if (q_ff.aw_got && q_ff.w_got && !q_ff.bvalid) begin
      nxt_q.aw_got = 1'b0;
      nxt_q.w_got = 1'b0;
      nxt_q.bvalid = 1'b1;
      ctrl_wr = (q_ff.awaddr == dsc_pkg::ADDR_CTRL);
      nxt_q.bresp = (ctrl_wr || q_ff.awaddr == dsc_pkg::ADDR_STATUS ||
                     q_ff.awaddr == dsc_pkg::ADDR_MERR ||
                     q_ff.awaddr == dsc_pkg::ADDR_STRAPS) ?
                    dsc_pkg::RESP_OKAY : dsc_pkg::RESP_DECERR;
      if (ctrl_wr && q_ff.wstrb[0]) begin
        nxt_q.hw_sel = q_ff.wdata[dsc_pkg::CTRL_HW_SEL_BIT];
        al_clr = q_ff.wdata[dsc_pkg::CTRL_AL_CLR_BIT];
      end
      // node 0 is not a legal address, the write is dropped
      if (ctrl_wr && q_ff.wstrb[1] && q_ff.wdata[15:8] >= dsc_pkg::NODE_MIN)
      begin
        nxt_q.sw_node = q_ff.wdata[15:8];
      end
    end
    if (q_ff.bvalid && I_BREADY) begin
      nxt_q.bvalid = 1'b0;
    end

    // local error event beats a same-cycle clear
    if (I_ERR_LOCAL_EVT) begin
      nxt_q.al_err = 1'b1;
    end else if (al_clr) begin
      nxt_q.al_err = 1'b0;
    end

    // ----------------------------------------------------------------
    // AXI4-Lite read
    // ----------------------------------------------------------------
    unique case (I_ARADDR)
      dsc_pkg::ADDR_CTRL: begin
        rd = {16'h0000, q_ff.sw_node, 6'h00, 1'b0, q_ff.hw_sel};
        rd_hit = 1'b1;
      end
      dsc_pkg::ADDR_STATUS: begin
        rd = {2'h0, q_ff.strap.axis_idx, q_ff.strap.node_sw, q_ff.node,
              3'h0, q_ff.al_err, q_ff.pins.port0_link, q_ff.lss_inact,
              q_ff.load_def, q_ff.autorun_en, q_ff.native_can,
              q_ff.hall_gnd, q_ff.st};
        rd_hit = 1'b1;
      end
      dsc_pkg::ADDR_MERR: begin
        rd = 32'h0000_0000;
        rd[dsc_pkg::MERR_INVALID_SETUP_BIT] = q_ff.merr_bad_setup;
        rd_hit = 1'b1;
      end
      dsc_pkg::ADDR_STRAPS: begin
        rd = {17'h00000, q_ff.strap};
        rd_hit = 1'b1;
      end
      default: begin
        rd = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
    if (I_ARVALID && O_ARREADY) begin
      nxt_q.rvalid = 1'b1;
      nxt_q.rdata = rd;
      nxt_q.rresp = rd_hit ? dsc_pkg::RESP_OKAY : dsc_pkg::RESP_DECERR;
    end else if (q_ff.rvalid && I_RREADY) begin
      nxt_q.rvalid = 1'b0;
    end

    // ----------------------------------------------------------------
    // indicators
    // ----------------------------------------------------------------
    if (I_SETUP_RESET_LOOP) begin
      nxt_q.run_led = pat.flicker;
      nxt_q.err_led = ~pat.flicker;
    end else begin
      if (I_ERR_CRITICAL) begin
        nxt_q.err_led = 1'b1;
      end else if (I_ERR_WATCHDOG) begin
        nxt_q.err_led = pat.double_a;
      end else if (q_ff.al_err && I_SLAVE_STATE != dsc_pkg::SLV_INIT) begin
        nxt_q.err_led = pat.single_a;
      end else if (I_ERR_CONFIG) begin
        nxt_q.err_led = pat.blink_a;
      end else if (q_ff.al_err) begin
        nxt_q.err_led = pat.flicker;
      end else begin
        nxt_q.err_led = 1'b0;
      end
      // run uses the opposite phase, and yields to a lit error led
      unique case (I_SLAVE_STATE)
        dsc_pkg::SLV_PREOP: nxt_q.run_led = pat.blink_b;
        dsc_pkg::SLV_SAFEOP: nxt_q.run_led = pat.single_b;
        dsc_pkg::SLV_OP: nxt_q.run_led = 1'b1;
        default: nxt_q.run_led = 1'b0;
      endcase
      if (nxt_q.err_led) begin
        nxt_q.run_led = 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // state register
  // ------------------------------------------------------------------
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      q_ff <= '0;
      q_ff.st <= dsc_pkg::ST_SETTLE;
      q_ff.sw_node <= dsc_pkg::DEFAULT_NODE;
      q_ff.node <= dsc_pkg::DEFAULT_NODE;
      q_ff.hw_sel <= dsc_pkg::CTRL_HW_SEL_RST;
      q_ff.setup_ok <= 1'b1;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign O_EE_DISABLE_ADDR = dsc_pkg::EE_DISABLE_ADDR;
  assign O_RUN_LED = q_ff.run_led;
  assign O_ERR_LED = q_ff.err_led;
  assign O_NODE_NUMBER = q_ff.node;
  assign O_NATIVE_CAN_MODE = q_ff.native_can;
  assign O_LSS_INACTIVE = q_ff.lss_inact;
  assign O_SLAVE_MODE = (q_ff.st == dsc_pkg::ST_SLAVE);
  assign O_PROG_START = q_ff.prog_start;
  assign O_LOAD_DEFAULTS = q_ff.load_def;
  assign O_AL_ERR_IND = q_ff.al_err;
  // port 1 never gates operation; only the upstream port counts
  assign O_UPSTREAM_OK = q_ff.pins.port0_link;
  assign O_AWREADY = ~q_ff.aw_got & ~q_ff.bvalid;
  assign O_WREADY = ~q_ff.w_got & ~q_ff.bvalid;
  assign O_BVALID = q_ff.bvalid;
  assign O_BRESP = q_ff.bresp;
  assign O_ARREADY = ~q_ff.rvalid;
  assign O_RVALID = q_ff.rvalid;
  assign O_RDATA = q_ff.rdata;
  assign O_RRESP = q_ff.rresp;

endmodule // dsc_startup_top

// ---- verification/dsc_far_model.sv ----
// far side stand-in: nonvolatile word store and slave state machine
// assumes requests come from the bench on the drive's clock
module dsc_far_model (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [15:0] i_ee_addr,
  input wire logic i_ee_wr,
  input wire logic [15:0] i_ee_wdata,
  input wire logic [3:0] i_req_state,
  output logic [15:0] o_ee_word,
  output logic [3:0] o_slave_state
);
  // ----------------------------------------------------------------
  // storage and state
  // ----------------------------------------------------------------
  logic [15:0] ee_ff;
  // no reset: the word must survive the drive's power cycle
  always_ff @(posedge i_clk) begin
    if (i_ee_wr) begin
      ee_ff <= i_ee_wdata;
    end
  end
  assign o_ee_word = (i_ee_addr == dsc_pkg::EE_DISABLE_ADDR) ? ee_ff : ~ee_ff;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_slave_state <= dsc_pkg::SLV_INIT;
    end else begin
      o_slave_state <= i_req_state;
    end
  end
endmodule // dsc_far_model

// ---- verification/dsc_startup_chk.sv ----
// relations between the startup/led block's ports over time
// assumes binding onto every dsc_startup_top instance
module dsc_startup_chk (
  input wire logic I_CLK,
  input wire logic I_ARST_N,
  input wire logic [3:0] I_SLAVE_STATE,
  input wire logic I_ERR_CRITICAL,
  input wire logic I_ERR_WATCHDOG,
  input wire logic I_ERR_CONFIG,
  input wire logic I_ERR_LOCAL_EVT,
  input wire logic I_SETUP_RESET_LOOP,
  input wire logic I_PORT0_LINK,
  input wire logic O_RUN_LED,
  input wire logic O_ERR_LED,
  input wire logic O_AL_ERR_IND,
  input wire logic O_PROG_START,
  input wire logic O_NATIVE_CAN_MODE,
  input wire logic O_LSS_INACTIVE,
  input wire logic O_UPSTREAM_OK,
  input wire logic [15:0] O_EE_DISABLE_ADDR,
  input wire logic O_RVALID,
  input wire logic O_ARREADY
);
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_ARST_N);
  logic quiet;
  assign quiet = !(I_ERR_CRITICAL | I_ERR_WATCHDOG | I_ERR_CONFIG |
    I_ERR_LOCAL_EVT | I_SETUP_RESET_LOOP | O_AL_ERR_IND);
  sequence s_pulse;
    O_PROG_START ##1 !O_PROG_START;
  endsequence
  leds_exclusive_a: assert property (!(O_RUN_LED && O_ERR_LED))
    else $error("run and error led lit together");
  disable_addr_a: assert property (O_EE_DISABLE_ADDR == 16'h2000)
    else $error("disable word address wrong");
  crit_err_on_a: assert property (
    I_ERR_CRITICAL && !I_SETUP_RESET_LOOP |=> O_ERR_LED && !O_RUN_LED)
    else $error("critical failure not steady on");
  op_run_on_a: assert property (
    quiet && I_SLAVE_STATE == dsc_pkg::SLV_OP |=> O_RUN_LED)
    else $error("run led not on in operational");
  init_dark_a: assert property (
    quiet && I_SLAVE_STATE == dsc_pkg::SLV_INIT |=> !O_RUN_LED && !O_ERR_LED)
    else $error("leds lit in quiet init");
  start_pulse_a: assert property (
    O_PROG_START |-> O_NATIVE_CAN_MODE ##0 s_pulse)
    else $error("program start outside native mode or too long");
  lss_canopen_a: assert property (O_LSS_INACTIVE |-> !O_NATIVE_CAN_MODE)
    else $error("lss inactive in native mode");
  port0_sync_a: assert property (I_PORT0_LINK [*4] |-> O_UPSTREAM_OK)
    else $error("upstream link not reported");
  ar_blocked_a: assert property (O_RVALID |-> !O_ARREADY)
    else $error("read address taken while answer pending");
endmodule // dsc_startup_chk

bind dsc_startup_top dsc_startup_chk chk_i (.*);

// ---- verification/drive_startup_config_and_status_leds_bench.sv ----
// self-checking bench for dsc_startup_top with the far side model
// assumes shortened hall, flicker and slot counts at the instance
module drive_startup_config_and_status_leds_bench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [3:0] sw; logic [1:0] ax; logic pr, ov; logic [2:0] hl;
    logic pv, sv, ds; logic [7:0] nd; logic nc, sl, ls;
  } dsc_row_s;
  logic I_CLK, I_ARST_N, I_PROTOCOL_SELECT_SWITCH, I_MODE_OVERRIDE_SWITCH;
  logic I_SWITCH_VARIANT, I_PORT0_LINK, I_PORT1_LINK, I_MOTOR_SUPPLY;
  logic I_PROG_VALID, I_SETUP_VALID, I_SETUP_RESET_LOOP, I_ERR_CRITICAL;
  logic I_ERR_WATCHDOG, I_ERR_LOCAL_EVT, I_ERR_CONFIG, O_RUN_LED, O_ERR_LED;
  logic O_NATIVE_CAN_MODE, O_LSS_INACTIVE, O_SLAVE_MODE, O_PROG_START;
  logic O_LOAD_DEFAULTS, O_AL_ERR_IND, O_UPSTREAM_OK, I_AWVALID, O_AWREADY;
  logic I_WVALID, O_WREADY, O_BVALID, I_BREADY, I_ARVALID, O_ARREADY;
  logic O_RVALID, I_RREADY, ee_wr, seen;
  logic [1:0] I_AXIS_INDEX, O_BRESP, O_RRESP, rs;
  logic [2:0] I_HALL;
  logic [3:0] I_NODE_NUMBER_SWITCH, I_SLAVE_STATE, I_WSTRB, req;
  logic [7:0] O_NODE_NUMBER, I_AWADDR, I_ARADDR;
  logic [15:0] I_EE_DISABLE_WORD, O_EE_DISABLE_ADDR, ee_d;
  logic [31:0] I_WDATA, O_RDATA, rd_d;
  int num_errors, cmp_count;
  dsc_row_s rows[7] = '{
    '{4'h1, 2'h0, 1, 0, 3'h7, 1, 0, 0, 8'h09, 1, 0, 0},
    '{4'hE, 2'h0, 0, 0, 3'h7, 1, 0, 0, 8'h71, 0, 1, 0},
    '{4'hF, 2'h3, 1, 0, 3'h7, 0, 0, 0, 8'h7C, 1, 1, 0},
    '{4'h0, 2'h0, 1, 0, 3'h0, 1, 1, 0, 8'hFF, 1, 1, 0},
    '{4'h0, 2'h0, 0, 0, 3'h7, 1, 1, 0, 8'hFF, 0, 1, 1},
    '{4'h0, 2'h1, 1, 1, 3'h7, 1, 0, 0, 8'h02, 0, 1, 0},
    '{4'h2, 2'h0, 1, 0, 3'h7, 1, 0, 1, 8'h11, 1, 1, 0}};
  dsc_startup_top #(.P_HALL_HOLD_CYC(20), .P_FLICKER_CYC(4),
    .P_SLOT_CYC(8)) uut (.*);
  dsc_far_model far_i (.i_clk(I_CLK), .i_arst_n(I_ARST_N),
    .i_ee_addr(O_EE_DISABLE_ADDR), .i_ee_wr(ee_wr), .i_ee_wdata(ee_d),
    .i_req_state(req), .o_ee_word(I_EE_DISABLE_WORD),
    .o_slave_state(I_SLAVE_STATE));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [39:0] g, input logic [39:0] e);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    I_ARADDR <= a;
    I_ARVALID <= 1;
    do @(posedge I_CLK); while (!O_ARREADY && n++ < 50);
    I_ARVALID <= 0;
    do @(posedge I_CLK); while (!O_RVALID && n++ < 50);
    rd_d = O_RDATA;
    rs = O_RRESP;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    int n;
    aw = 1;
    w = 1;
    n = 0;
    I_AWADDR <= a;
    I_WDATA <= d;
    I_AWVALID <= 1;
    I_WVALID <= 1;
    while ((aw || w) && n++ < 50) begin
      @(posedge I_CLK);
      if (aw && O_AWREADY) begin aw = 0; I_AWVALID <= 0; end
      if (w && O_WREADY) begin w = 0; I_WVALID <= 0; end
    end
    do @(posedge I_CLK); while (!O_BVALID && n++ < 50);
    rs = O_BRESP;
  endtask
  // power cycle with the straps of one row; the stored word is rewritten from the row's disable flag
  task automatic pu(input dsc_row_s r);
    int n;
    n = 0;
    @(posedge I_CLK);
    I_ARST_N <= 0;
    {I_NODE_NUMBER_SWITCH, I_AXIS_INDEX} <= {r.sw, r.ax};
    {I_PROTOCOL_SELECT_SWITCH, I_MODE_OVERRIDE_SWITCH} <= {r.pr, r.ov};
    {I_HALL, I_PROG_VALID, I_SETUP_VALID} <= {r.hl, r.pv, r.sv};
    I_MOTOR_SUPPLY <= 0;
    ee_wr <= 1;
    ee_d <= r.ds ? dsc_pkg::EE_DISABLE_VAL : 16'hFFFF;
    @(posedge I_CLK);
    ee_wr <= 0;
    repeat (11) @(posedge I_CLK);
    I_ARST_N <= 1;
    do rd(dsc_pkg::ADDR_STATUS); while (rd_d[5:3] == 0 && n++ < 40);
  endtask
  // windows span whole periods, so the pattern phase does not matter
  task automatic led(input logic [3:0] s, input logic [2:0] e,
    input int n, input int er, input int rn);
    int ce, cr;
    ce = 0;
    cr = 0;
    req <= s;
    {I_ERR_CRITICAL, I_ERR_WATCHDOG, I_ERR_CONFIG} <= e;
    repeat (80) @(posedge I_CLK);
    repeat (n) begin
      @(posedge I_CLK);
      ce += O_ERR_LED;
      cr += O_RUN_LED;
    end
    chk(ce, er);
    if (er == 0) chk(cr, rn);
  endtask
  task automatic complete_run;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // stimulus
  // ----------------------------------------------------------------
  initial begin
    I_CLK = 0;
    forever #4 I_CLK = ~I_CLK;
  end
  initial begin
    repeat (20000) @(posedge I_CLK);
    num_errors++;
    complete_run;
  end
  initial begin
    {I_ARST_N, I_SWITCH_VARIANT, I_PORT1_LINK, I_SETUP_RESET_LOOP} = 0;
    {I_ERR_CRITICAL, I_ERR_WATCHDOG, I_ERR_CONFIG, I_ERR_LOCAL_EVT} = 0;
    {I_AWVALID, I_WVALID, I_ARVALID, ee_wr, I_MOTOR_SUPPLY} = 0;
    {I_PORT0_LINK, I_BREADY, I_RREADY} = 3'h7;
    {I_AWADDR, I_ARADDR, I_WDATA, I_WSTRB, ee_d} = 0;
    I_WSTRB = 4'hF;
    req = dsc_pkg::SLV_INIT;
    foreach (rows[i]) begin
      pu(rows[i]);
      chk({O_NODE_NUMBER, O_NATIVE_CAN_MODE, O_SLAVE_MODE, O_LSS_INACTIVE,
        O_UPSTREAM_OK}, {rows[i].nd, rows[i].nc, rows[i].sl, rows[i].ls,
        1'b1});
      I_MOTOR_SUPPLY <= 1;
      seen = 0;
      repeat (12) begin
        @(posedge I_CLK);
        seen |= O_PROG_START;
      end
      chk(seen, !rows[i].sl);
    end
    rd(dsc_pkg::ADDR_CTRL);
    chk(rd_d & 32'hFF01, 32'hFF00);
    wr(dsc_pkg::ADDR_CTRL, 32'h0100);
    wr(dsc_pkg::ADDR_CTRL, 32'h0000);
    rd(dsc_pkg::ADDR_CTRL);
    chk(rd_d[15:8], 8'h01);
    wr(8'h10, 32'h1);
    chk(rs, dsc_pkg::RESP_DECERR);
    rd(8'h10);
    chk({rs, rd_d}, {dsc_pkg::RESP_DECERR, 32'h0});
    I_SWITCH_VARIANT <= 1;
    pu('{4'h3, 2'h1, 1, 0, 3'h0, 1, 1, 0, 8'h1A, 1, 1, 0});
    rd(dsc_pkg::ADDR_MERR);
    chk({rd_d[2], O_LOAD_DEFAULTS, O_NODE_NUMBER}, {2'h3, 8'h1A});
    I_SWITCH_VARIANT <= 0;
    led(dsc_pkg::SLV_OP, 3'h0, 48, 0, 48);
    led(dsc_pkg::SLV_INIT, 3'h0, 48, 0, 0);
    led(dsc_pkg::SLV_PREOP, 3'h0, 16, 0, 8);
    led(dsc_pkg::SLV_SAFEOP, 3'h0, 48, 0, 8);
    led(dsc_pkg::SLV_OP, 3'h4, 48, 48, 0);
    led(dsc_pkg::SLV_OP, 3'h2, 64, 16, 0);
    led(dsc_pkg::SLV_OP, 3'h1, 16, 8, 0);
    I_ERR_LOCAL_EVT <= 1;
    @(posedge I_CLK);
    I_ERR_LOCAL_EVT <= 0;
    led(dsc_pkg::SLV_OP, 3'h0, 48, 8, 0);
    rd(dsc_pkg::ADDR_STATUS);
    chk(rd_d[12], 1'b1);
    led(dsc_pkg::SLV_INIT, 3'h0, 8, 4, 0);
    wr(dsc_pkg::ADDR_CTRL, 32'h0102);
    chk(O_AL_ERR_IND, 1'b0);
    I_SETUP_RESET_LOOP <= 1;
    led(dsc_pkg::SLV_OP, 3'h0, 8, 4, 0);
    complete_run;
  end
endmodule // drive_startup_config_and_status_leds_bench
